// *** hdl/can_pkg.sv ***
// Purpose: Shared constants for the alarm notification block
// Assumes: Byte registers held in the low bits of 32-bit AXI4-Lite words
// Notes:   Register map offsets are word indexes; byte address = 4 * index
package can_pkg;
   localparam int            CAN_AW           = 6;
   localparam logic [7:0]    IDX_RESULT_HIGH  = 8'h05;
   localparam logic [7:0]    IDX_RESULT_LOW   = 8'h06;
   localparam logic [7:0]    IDX_STATUS       = 8'h07;
   localparam logic [7:0]    IDX_NOTIFY_CFG   = 8'h08;
   localparam logic [7:0]    IDX_THRESH_HIGH  = 8'h09;
   localparam logic [7:0]    IDX_THRESH_LOW   = 8'h0A;
   localparam logic [7:0]    IDX_MEASURE_CONFIG     = 8'h04;
   localparam logic [7:0]    RST_NOTIFY_CFG   = 8'h11;
   localparam logic [7:0]    RST_THRESH       = 8'h00;
   localparam logic [7:0]    RST_MEASURE_CONFIG     = 8'h00;
   localparam int            POS_VIOL_CLR     = 0;
   localparam int            POS_LATCH_CLR    = 1;
   localparam int            POS_VIOLATION    = 2;
   localparam int            POS_LATCHED      = 3;
   localparam int            POS_NEW_RESULT   = 4;
   localparam int            POS_DIRECTION    = 0;
   localparam int            POS_FUNC_LO      = 1;
   localparam int            POS_POLARITY     = 4;
   localparam logic [2:0]    FN_OFF           = 3'h0;
   localparam logic [2:0]    FN_VIOLATION     = 3'h1;
   localparam logic [2:0]    FN_NEW_RESULT    = 3'h2;
   localparam logic [2:0]    FN_BUSY          = 3'h3;
   localparam logic [2:0]    FN_EARLY_START   = 3'h4;
   localparam logic [1:0]    MODE_IDLE        = 2'h0;
   localparam logic [1:0]    MODE_SINGLE      = 2'h1;
   localparam logic [1:0]    MODE_CONT        = 2'h2;
   localparam logic [1:0]    RESP_OKAY        = 2'h0;
   localparam logic [1:0]    RESP_SLVERR      = 2'h2;
   localparam int            MEAS_TIME_NS     = 2000;
   localparam int            CLK_PERIOD_NS    = 100;
   localparam int            MEAS_CYCLES      = MEAS_TIME_NS / CLK_PERIOD_NS;
   localparam int            EARLY_CYCLES     = 2;
endpackage : can_pkg

// *** hdl/can_evt_if.sv ***
// Purpose: Measurement event bundle between the sequencer and the top
// Assumes: Single clock domain
// Notes:   All strobes are one-cycle pulses
`timescale 1ns/1ps
interface can_evt_if;
   logic        busy;         // Sequence in progress
   logic        early_start;  // Pulse shortly before a continuous start
   logic        done;         // Pulse at end of sequence
   logic [15:0] result;       // Result valid with done
   logic        single_ack;   // Single-shot trigger consumed
   modport seq (output busy, early_start, done, result, single_ack);
   modport top (input busy, early_start, done, result, single_ack);
endinterface : can_evt_if

// *** hdl/can_meas_seq.sv ***
// Purpose: Stand-in measurement sequencer producing end-of-sequence events
// Assumes: Result sample is taken from an input at sequence end
// Notes:   Continuous mode restarts after a fixed gap
`timescale 1ns/1ps
module can_meas_seq #(
   parameter int MEAS_CYCLES = can_pkg::MEAS_CYCLES
) (
   input  wire logic        aclk,         // System clock
   input  wire logic        aresetn,      // Sync reset, active low
   input  wire logic [1:0]  mode,         // Operating mode
   input  wire logic [15:0] sample,       // Raw result source
   can_evt_if.seq           evt           // Event bundle
);
   logic [15:0] cnt;
   logic        gap;

   // Gap between continuous sequences; early start fires near its end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt  <= 16'h0000;
         gap  <= 1'b0;
         evt.busy <= 1'b0;
         evt.done <= 1'b0;
         evt.single_ack <= 1'b0;
         evt.early_start <= 1'b0;
         evt.result <= 16'h0000;
      end else begin
         evt.done <= 1'b0;
         evt.single_ack <= 1'b0;
         evt.early_start <= 1'b0;
         if (evt.busy) begin
            if (cnt == 16'(MEAS_CYCLES - 1)) begin
               evt.busy   <= 1'b0;
               evt.done   <= 1'b1;
               evt.result <= sample;
               cnt        <= 16'h0000;
               gap        <= 1'b1;
            end else begin
               cnt <= cnt + 16'h0001;
            end
         end else if (mode == can_pkg::MODE_SINGLE) begin
            evt.busy       <= 1'b1;
            evt.single_ack <= 1'b1;
            cnt            <= 16'h0000;
         end else if (mode == can_pkg::MODE_CONT) begin
            if (gap && cnt != 16'(MEAS_CYCLES - 1)) begin
               cnt <= cnt + 16'h0001;
               evt.early_start <= (cnt ==
                  16'(MEAS_CYCLES - 1 - can_pkg::EARLY_CYCLES));
            end else begin
               evt.busy <= 1'b1;
               gap      <= 1'b0;
               cnt      <= 16'h0000;
            end
         end else begin
            gap <= 1'b0;
            cnt <= 16'h0000;
         end
      end
   end
endmodule : can_meas_seq

// *** hdl/can_notify_top.sv ***
// Purpose: Status flags, notification pin and alarm threshold registers
// Assumes: AXI4-Lite slave, one outstanding write and read
// Notes:   Violation and new-result pin events are latched at sequence end until cleared
// Contract
// RL1 - Status bit 3 shows the notification pin latched active.
// RL2 - Latched flag set at sequence end on latching condition; stays set.
// RL3 - Write 1 to status bit 1 clears latch, pin inactive; reads 0.
// RL4 - Status bit 2 sets at sequence end when result violates threshold.
// RL5 - Write 1 to status bit 0 clears violation flag; reads 0.
// RL6 - Pin configuration at 0x08, reset 0x11.
// RL7 - Software writes zero to configuration bits 7:5.
// RL8 - Configuration bit 4: 0 active low, 1 active high.
// RL9 - Any polarity write forces the pin inactive.
// RL10 - Function 000 off, 001 violation, 010 new result.
// RL11 - Function 011 shows sensor busy.
// RL12 - Function 100 early start, only in continuous mode.
// RL13 - Direction 0: violation when result is below threshold.
// RL14 - Direction 1: violation when result is above threshold.
// RL15 - Threshold is high byte then low byte, signed.
// RL16 - Threshold high byte at 0x09, read/write, reset 0x00.
// RL17 - New-result flag bit 4 set each sequence end; result low read clears.
// RL18 - Mode 00 idle, 01 single then self-clears, 10 continuous, 11 idle.
// RL19 - Threshold low byte at 0x0A, read/write, reset 0x00.
// RL20 - Result is signed 16-bit, compared signed.
// RL21 - Pin latches active until clear, polarity write or reset.
// RL22 - Function codes 101 to 111 keep the pin inactive.
// RL23 - Strict less-than or greater-than comparison.
`timescale 1ns/1ps
module can_notify_top #(
   parameter int MEAS_CYCLES = can_pkg::MEAS_CYCLES
) (
   input  wire logic                      aclk,    // System clock
   input  wire logic                      aresetn, // Sync reset, low
   input  wire logic [can_pkg::CAN_AW-1:0] awaddr, // Write address
   input  wire logic                      awvalid, // Write addr valid
   output logic                           awready, // Write addr ready
   input  wire logic [31:0]               wdata,   // Write data
   input  wire logic [3:0]                wstrb,   // Write strobes
   input  wire logic                      wvalid,  // Write data valid
   output logic                           wready,  // Write data ready
   output logic [1:0]                     bresp,   // Write response
   output logic                           bvalid,  // Write resp valid
   input  wire logic                      bready,  // Write resp ready
   input  wire logic [can_pkg::CAN_AW-1:0] araddr, // Read address
   input  wire logic                      arvalid, // Read addr valid
   output logic                           arready, // Read addr ready
   output logic [31:0]                    rdata,   // Read data
   output logic [1:0]                     rresp,   // Read response
   output logic                           rvalid,  // Read data valid
   input  wire logic                      rready,  // Read data ready
   input  wire logic [15:0]               sample,  // Measurement source
   output logic                           notify_pin // Notification pin
);
   can_evt_if evt ();

   logic [7:0]  notify_pin_config;
   logic [7:0]  alarm_threshold_high;
   logic [7:0]  alarm_threshold_low;
   logic [1:0]  measurement_mode_select;
   logic [15:0] result;
   logic        new_result_flag;
   logic        violation_flag;
   logic        notify_latched_flag;
   logic        aw_held;
   logic        w_held;
   logic [can_pkg::CAN_AW-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_go;
   logic        rd_go;
   logic [7:0]  wr_idx;
   logic        wr_lane0;
   logic        cfg_wr;
   logic        status_wr;
   logic        violation;
   logic        latch_cond;
   logic        pin_active;
   logic [2:0]  func;
   logic        polarity;

   function automatic logic [7:0] word_index(
      input logic [can_pkg::CAN_AW-1:0] a);
      word_index = 8'(a[can_pkg::CAN_AW-1:2]);
   endfunction : word_index

   can_meas_seq #(
      .MEAS_CYCLES (MEAS_CYCLES)
   ) u_seq (
      .aclk    (aclk),
      .aresetn (aresetn),
      .mode    (measurement_mode_select),
      .sample  (sample),
      .evt     (evt)
   );

   // Write channel: address and data taken in either order
   assign wr_go    = aw_held && w_held && !bvalid;
   assign wr_idx   = word_index(aw_addr);
   assign wr_lane0 = wr_go && w_strb[0];
   assign cfg_wr   = wr_lane0 && wr_idx == can_pkg::IDX_NOTIFY_CFG;
   assign status_wr = wr_lane0 && wr_idx == can_pkg::IDX_STATUS;
   assign func     = notify_pin_config[can_pkg::POS_FUNC_LO +: 3];
   assign polarity = notify_pin_config[can_pkg::POS_POLARITY];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         awready <= 1'b0;
         wready  <= 1'b0;
         aw_addr <= '0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= can_pkg::RESP_OKAY;
      end else begin
         awready <= !aw_held && !awready && !(awvalid && awready);
         wready  <= !w_held && !wready && !(wvalid && wready);
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
            wready <= 1'b0;
         end
         if (wr_go) begin
            bvalid  <= 1'b1;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bresp   <= (wr_idx >= can_pkg::IDX_MEASURE_CONFIG &&
                        wr_idx <= can_pkg::IDX_THRESH_LOW) ?
                       can_pkg::RESP_OKAY : can_pkg::RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Configuration and threshold registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         notify_pin_config    <= can_pkg::RST_NOTIFY_CFG; // RL6
         alarm_threshold_high <= can_pkg::RST_THRESH;     // RL16
         alarm_threshold_low  <= can_pkg::RST_THRESH;     // RL19
      end else if (wr_lane0) begin
         if (wr_idx == can_pkg::IDX_NOTIFY_CFG) begin
            // Reserved bits stored as written; software keeps them zero
            notify_pin_config <= w_data[7:0]; // RL7
         end
         if (wr_idx == can_pkg::IDX_THRESH_HIGH) begin
            alarm_threshold_high <= w_data[7:0]; // RL16
         end
         if (wr_idx == can_pkg::IDX_THRESH_LOW) begin
            alarm_threshold_low <= w_data[7:0]; // RL19
         end
      end
   end

   // Mode field; single shot clears itself when the sequencer takes it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         measurement_mode_select <= can_pkg::RST_MEASURE_CONFIG[1:0];
      end else if (wr_lane0 && wr_idx == can_pkg::IDX_MEASURE_CONFIG) begin
         measurement_mode_select <= w_data[1:0]; // RL18
      end else if (evt.single_ack) begin
         measurement_mode_select <= can_pkg::MODE_IDLE; // RL18
      end
   end

   // Signed strict comparison against the concatenated threshold
   always_comb begin
      if (notify_pin_config[can_pkg::POS_DIRECTION]) begin
         violation = $signed(evt.result) > // RL14 RL23 RL20
                     $signed({alarm_threshold_high, alarm_threshold_low});
      end else begin
         violation = $signed(evt.result) < // RL13 RL23 RL15
                     $signed({alarm_threshold_high, alarm_threshold_low});
      end
   end

   always_comb begin
      case (func)
         can_pkg::FN_VIOLATION:  latch_cond = evt.done && violation; // RL10
         can_pkg::FN_NEW_RESULT: latch_cond = evt.done;              // RL10
         default:                latch_cond = 1'b0;                  // RL22
      endcase
   end

   // Result capture and new-result flag; a set beats a same-cycle read clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result          <= 16'h0000;
         new_result_flag <= 1'b0;
      end else if (evt.done) begin
         result          <= evt.result;
         new_result_flag <= 1'b1; // RL17
      end else if (rd_go && word_index(araddr) == can_pkg::IDX_RESULT_LOW) begin
         new_result_flag <= 1'b0; // RL17
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         violation_flag <= 1'b0;
      end else if (evt.done && violation) begin
         violation_flag <= 1'b1; // RL4
      end else if (status_wr && w_data[can_pkg::POS_VIOL_CLR]) begin
         violation_flag <= 1'b0; // RL5
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         notify_latched_flag <= 1'b0;
      end else if (latch_cond) begin
         notify_latched_flag <= 1'b1; // RL1 RL2
      end else if (status_wr && w_data[can_pkg::POS_LATCH_CLR]) begin
         notify_latched_flag <= 1'b0; // RL3
      end else if (cfg_wr) begin
         notify_latched_flag <= 1'b0; // RL9
      end
   end

   // Live functions follow their source; latched ones follow the flag
   always_comb begin
      case (func)
         can_pkg::FN_BUSY:      pin_active = evt.busy;           // RL11
         can_pkg::FN_EARLY_START:
            pin_active = evt.early_start &&
                         measurement_mode_select == can_pkg::MODE_CONT; // RL12
         can_pkg::FN_VIOLATION,
         can_pkg::FN_NEW_RESULT: pin_active = notify_latched_flag; // RL21
         default:               pin_active = 1'b0;              // RL22
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         notify_pin <= !can_pkg::RST_NOTIFY_CFG[can_pkg::POS_POLARITY];
      end else if (cfg_wr) begin
         notify_pin <= !w_data[can_pkg::POS_POLARITY]; // RL9
      end else begin
         notify_pin <= polarity ? pin_active : !pin_active; // RL8
      end
   end

   // Read channel
   assign rd_go = arvalid && arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= can_pkg::RESP_OKAY;
      end else begin
         arready <= !rvalid && !arready;
         if (rd_go) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= can_pkg::RESP_OKAY;
            case (word_index(araddr))
               can_pkg::IDX_RESULT_HIGH: rdata <= {24'h00_0000, result[15:8]};
               can_pkg::IDX_RESULT_LOW:  rdata <= {24'h00_0000, result[7:0]};
               can_pkg::IDX_STATUS:      rdata <= {27'h000_0000,
                  new_result_flag, notify_latched_flag, violation_flag,
                  2'b00}; // RL3 RL5
               can_pkg::IDX_MEASURE_CONFIG:    rdata <= {30'h0000_0000,
                  measurement_mode_select};
               can_pkg::IDX_NOTIFY_CFG:  rdata <= {24'h00_0000,
                  notify_pin_config};
               can_pkg::IDX_THRESH_HIGH: rdata <= {24'h00_0000,
                  alarm_threshold_high};
               can_pkg::IDX_THRESH_LOW:  rdata <= {24'h00_0000,
                  alarm_threshold_low};
               default: begin
                  rdata <= 32'h0000_0000;
                  rresp <= can_pkg::RESP_SLVERR;
               end
            endcase
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   a_latch_set: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
      latch_cond |=> notify_latched_flag)
      else $error("latched flag not set after latching condition");
   a_latch_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      status_wr && w_data[1] && !latch_cond |=> !notify_latched_flag)
      else $error("latched flag not cleared by write");
   a_viol_set: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
      evt.done && violation |=> violation_flag)
      else $error("violation flag not set");
   a_viol_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
      violation_flag && !(status_wr && w_data[0]) |=> violation_flag)
      else $error("violation flag dropped without clear");
   a_pol_inactive: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
      cfg_wr |=> notify_pin == !$past(w_data[4]))
      else $error("pin not inactive after polarity write");
   a_reserved_off: assert property (@(posedge aclk) disable iff (!aresetn) // RL22
      func > 3'h4 && !cfg_wr |=> notify_pin == !polarity)
      else $error("pin active with reserved function");
   a_new_result: assert property (@(posedge aclk) disable iff (!aresetn) // RL17
      evt.done |=> new_result_flag && result == $past(evt.result))
      else $error("new result not captured");
   a_early_mode: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
      func == 3'h4 && measurement_mode_select != 2'h2 && !cfg_wr
      |=> notify_pin == !polarity)
      else $error("early start outside continuous mode");
   a_thresh_rst: assert property (@(posedge aclk) // RL6
      !aresetn |=> notify_pin_config == 8'h11 && alarm_threshold_high == 8'h00)
      else $error("configuration reset value wrong");
endmodule : can_notify_top

// *** verif/can_host_model.sv ***
// Purpose: Host model: AXI4-Lite master and notification pin watcher
// Assumes: One write and one read under way at a time
// Notes:   Waits without limit; the bench timeout cuts a hang short
`timescale 1ns/1ps
module can_host_model (
   input  wire logic       aclk,       // Clock
   output logic [5:0]      awaddr,     // Write address
   output logic            awvalid,    // Write addr valid
   input  wire logic       awready,    // Write addr ready
   output logic [31:0]     wdata,      // Write data
   output logic [3:0]      wstrb,      // Write strobes
   output logic            wvalid,     // Write data valid
   input  wire logic       wready,     // Write data ready
   input  wire logic [1:0] bresp,      // Write response
   input  wire logic       bvalid,     // Write resp valid
   output logic            bready,     // Write resp ready
   output logic [5:0]      araddr,     // Read address
   output logic            arvalid,    // Read addr valid
   input  wire logic       arready,    // Read addr ready
   input  wire logic [31:0] rdata,     // Read data
   input  wire logic [1:0] rresp,      // Read response
   input  wire logic       rvalid,     // Read data valid
   output logic            rready,     // Read data ready
   input  wire logic       notify_pin  // Pin under watch
);
   int hi_cnt = 0;

   initial begin
      awaddr = 6'h00;
      araddr = 6'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
   end

   // Cycles spent high, so short pulses are not missed between reads
   always @(posedge aclk)
      if (notify_pin === 1'b1)
         hi_cnt <= hi_cnt + 1;

   task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                     output logic [1:0] resp);
      @(posedge aclk);
      awaddr <= {idx[3:0], 2'b00};
      wdata <= {24'h00_0000, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // The slave may take address and data in either order
      fork
         begin
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (wready !== 1'b1);
            wvalid <= 1'b0;
         end
      join
      while (bvalid !== 1'b1) @(posedge aclk);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                     output logic [1:0] resp);
      @(posedge aclk);
      araddr <= {idx[3:0], 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : can_host_model

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the notification block
// Assumes: Host model drives the bus; reads are judged from a queue
// Notes:   Sequence length is shortened to keep the run brief
`timescale 1ns/1ps
module tb;
   localparam int MC    = 4;
   localparam int LIMIT = 20000;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [5:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, notify_pin, dir, v;
   logic [15:0] sample = 16'h0000;
   logic [15:0] lfsr = 16'h0029;
   logic [15:0] thr, smp;
   logic [33:0] exp_q[$];
   logic [33:0] tbl [5] = '{{1'b1, 16'h0100, 16'h0101, 1'b1},
      {1'b1, 16'h0100, 16'h0100, 1'b0}, {1'b0, 16'h0000, 16'hFFFF, 1'b1},
      {1'b0, 16'hFF00, 16'h0005, 1'b0}, {1'b1, 16'hFF00, 16'h0005, 1'b1}};
   logic [2:0]  rsv [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          n0;

   can_notify_top #(.MEAS_CYCLES(MC)) uut (.aclk, .aresetn, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .sample, .notify_pin);
   can_host_model host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .notify_pin);

   always #50 aclk = ~aclk;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_sim

   task automatic check(input string nm, input logic [33:0] seen, e);
      n_compared++;
      if (seen !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, seen);
      end
   endtask : check

   // A finished read is judged against the oldest note when one is queued
   always @(posedge aclk)
      if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0)
         check("read", {rresp, rdata}, exp_q.pop_front());

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e,
                         input logic [1:0] r = can_pkg::RESP_OKAY);
      logic [31:0] d;
      logic [1:0]  rr;
      exp_q.push_back({r, 24'h00_0000, e});
      host.rd(idx, d, rr);
   endtask : rd_chk

   task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                     input logic [1:0] r = can_pkg::RESP_OKAY);
      logic [1:0] rr;
      host.wr(idx, d, rr);
      check("bresp", {32'h0000_0000, rr}, {32'h0000_0000, r});
   endtask : wr

   task automatic pin_chk(input logic e);
      repeat (2) @(posedge aclk);
      check("pin", {33'h0, notify_pin}, {33'h0, e});
   endtask : pin_chk

   // Clears the new-result flag first so the poll sees only this run
   task automatic run_single();
      logic [31:0] d;
      logic [1:0]  rr;
      host.rd(can_pkg::IDX_RESULT_LOW, d, rr);
      wr(can_pkg::IDX_MEASURE_CONFIG, {6'h00, can_pkg::MODE_SINGLE});
      do host.rd(can_pkg::IDX_STATUS, d, rr); while (d[4] !== 1'b1);
   endtask : run_single

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      pin_chk(1'b0);
      rd_chk(can_pkg::IDX_NOTIFY_CFG, 8'h11);
      rd_chk(can_pkg::IDX_THRESH_HIGH, 8'h00);
      rd_chk(can_pkg::IDX_THRESH_LOW, 8'h00);
      rd_chk(can_pkg::IDX_STATUS, 8'h00);
      rd_chk(8'h00, 8'h00, can_pkg::RESP_SLVERR);
      wr(8'h0B, 8'h5A, can_pkg::RESP_SLVERR);
      repeat (4) begin
         lfsr = lfsr_next(lfsr);
         wr(can_pkg::IDX_THRESH_HIGH, lfsr[15:8]);
         wr(can_pkg::IDX_THRESH_LOW, lfsr[7:0]);
         rd_chk(can_pkg::IDX_THRESH_HIGH, lfsr[15:8]);
         rd_chk(can_pkg::IDX_THRESH_LOW, lfsr[7:0]);
      end
      foreach (tbl[i]) begin
         {dir, thr, smp, v} = tbl[i];
         wr(can_pkg::IDX_THRESH_HIGH, thr[15:8]);
         wr(can_pkg::IDX_THRESH_LOW, thr[7:0]);
         wr(can_pkg::IDX_NOTIFY_CFG, {4'h1, 3'h1, dir});
         sample <= smp;
         run_single();
         rd_chk(can_pkg::IDX_STATUS, {4'h1, v, v, 2'b00});
         pin_chk(v);
         rd_chk(can_pkg::IDX_MEASURE_CONFIG, 8'h00);
         rd_chk(can_pkg::IDX_RESULT_HIGH, smp[15:8]);
         rd_chk(can_pkg::IDX_RESULT_LOW, smp[7:0]);
         rd_chk(can_pkg::IDX_STATUS, {4'h0, v, v, 2'b00});
         wr(can_pkg::IDX_STATUS, 8'h02);
         pin_chk(1'b0);
         rd_chk(can_pkg::IDX_STATUS, {5'h00, v, 2'b00});
         wr(can_pkg::IDX_STATUS, 8'h01);
         rd_chk(can_pkg::IDX_STATUS, 8'h00);
      end
      wr(can_pkg::IDX_THRESH_HIGH, 8'h00);
      wr(can_pkg::IDX_THRESH_LOW, 8'h00);
      sample <= 16'h0010;
      wr(can_pkg::IDX_NOTIFY_CFG, 8'h13);
      run_single();
      pin_chk(1'b1);
      wr(can_pkg::IDX_NOTIFY_CFG, 8'h13);
      pin_chk(1'b0);
      wr(can_pkg::IDX_NOTIFY_CFG, 8'h03);
      pin_chk(1'b1);
      run_single();
      pin_chk(1'b0);
      wr(can_pkg::IDX_STATUS, 8'h03);
      pin_chk(1'b1);
      wr(can_pkg::IDX_NOTIFY_CFG, 8'h14);
      run_single();
      pin_chk(1'b1);
      rd_chk(can_pkg::IDX_STATUS, 8'h18);
      wr(can_pkg::IDX_NOTIFY_CFG, 8'h16);
      n0 = host.hi_cnt;
      run_single();
      check("busy", {33'h0, host.hi_cnt > n0}, 34'h1);
      pin_chk(1'b0);
      wr(can_pkg::IDX_NOTIFY_CFG, 8'h18);
      n0 = host.hi_cnt;
      run_single();
      check("early", {33'h0, host.hi_cnt == n0}, 34'h1);
      wr(can_pkg::IDX_MEASURE_CONFIG, {6'h00, can_pkg::MODE_CONT});
      repeat (100) @(posedge aclk);
      check("early", {33'h0, host.hi_cnt > n0}, 34'h1);
      wr(can_pkg::IDX_MEASURE_CONFIG, {6'h00, can_pkg::MODE_IDLE});
      foreach (rsv[i]) begin
         wr(can_pkg::IDX_NOTIFY_CFG, {4'h1, rsv[i], 1'b1});
         n0 = host.hi_cnt;
         run_single();
         pin_chk(1'b0);
         check("rsv", {33'h0, host.hi_cnt == n0}, 34'h1);
      end
      // Mode 11 must behave as idle: no sequence, so no new result
      rd_chk(can_pkg::IDX_RESULT_LOW, 8'h10);
      wr(can_pkg::IDX_MEASURE_CONFIG, {6'h00, 2'b11});
      repeat (4 * MC) @(posedge aclk);
      rd_chk(can_pkg::IDX_STATUS, 8'h04);
      @(posedge aclk);
      end_sim();
   end
endmodule : tb
